// file: include/uirq_regs.vh
`ifndef UIRQ_REGS_VH
`define UIRQ_REGS_VH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define UIRQ_ADDR_IE1 12'h000
`define UIRQ_ADDR_IE2 12'h004
`define UIRQ_ADDR_SERIAL_IRQ_FLAG_1 12'h008
`define UIRQ_ADDR_SERIAL_IRQ_FLAG_2 12'h00c
`define UIRQ_ADDR_CTRL 12'h010
`define UIRQ_ADDR_EVT 12'h014
`define UIRQ_ADDR_EVT_MASK 12'h018
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UIRQ_TX0_BIT 7
`define UIRQ_RX0_BIT 6
`define UIRQ_TX1_BIT 5
`define UIRQ_RX1_BIT 4
`define UIRQ_TX0_R_BIT 1
`define UIRQ_RX0_R_BIT 0
// Control register bits.
`define UIRQ_CTRL_GIE 0
`define UIRQ_CTRL_SRST0 1
`define UIRQ_CTRL_SRST1 2
`define UIRQ_CTRL_SYNC0 3
`define UIRQ_CTRL_TWO0 4
`define UIRQ_CTRL_SYNC1 5
`define UIRQ_CTRL_TWO1 6
`define UIRQ_CTRL_REDUCED 7
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UIRQ_CTRL_RESET 8'h06
`define UIRQ_ZERO8 8'h00
`endif

// file: rtl/uirq_unit_flags.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Transmit and receive flag pair of one serial unit
// ----------------------------------------------------------------------
module uirq_unit_flags (
    input wire pclk,
    input wire presetn,
    input wire soft_reset_bit,
    input wire tx_empty,
    input wire tx_load,
    input wire tx_ack,
    input wire rx_done,
    input wire rx_read,
    input wire wr_en,
    input wire wr_tx,
    input wire wr_rx,
    output reg tx_empty_flag,
    output reg rx_full_flag
);
    // A new event wins over any clear in the same cycle, except tx_load, which beats tx_empty.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_empty_flag <= 1'b1;
            rx_full_flag <= 1'b0;
        end else begin
            if (soft_reset_bit) begin
                tx_empty_flag <= 1'b1;
            end else if (tx_empty && !tx_load) begin
                tx_empty_flag <= 1'b1;
            end else if (tx_load || tx_ack) begin
                tx_empty_flag <= 1'b0;
            end else if (wr_en) begin
                tx_empty_flag <= wr_tx;
            end
            if (rx_done) begin
                rx_full_flag <= 1'b1;
            end else if (rx_read) begin
                rx_full_flag <= 1'b0;
            end else if (wr_en) begin
                rx_full_flag <= wr_rx;
            end
        end
    end
endmodule // uirq_unit_flags

// file: rtl/uirq_apb_slave.v
`timescale 1ns/1ps
`include "uirq_regs.vh"
// ----------------------------------------------------------------------
// APB decode: zero wait states, error on unmapped addresses
// ----------------------------------------------------------------------
module uirq_apb_slave (
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    output wire pready,
    output wire pslverr,
    output wire acc,
    output wire wr,
    output wire rd,
    output wire [6:0] hit
);
    assign pready = 1'b1;
    assign acc = psel && penable;
    assign hit[0] = (paddr == `UIRQ_ADDR_IE1);
    assign hit[1] = (paddr == `UIRQ_ADDR_IE2);
    assign hit[2] = (paddr == `UIRQ_ADDR_SERIAL_IRQ_FLAG_1);
    assign hit[3] = (paddr == `UIRQ_ADDR_SERIAL_IRQ_FLAG_2);
    assign hit[4] = (paddr == `UIRQ_ADDR_CTRL);
    assign hit[5] = (paddr == `UIRQ_ADDR_EVT);
    assign hit[6] = (paddr == `UIRQ_ADDR_EVT_MASK);
    assign pslverr = acc && (hit == 7'h00);
    assign wr = acc && pwrite && (hit != 7'h00);
    assign rd = acc && !pwrite && (hit != 7'h00);
endmodule // uirq_apb_slave

// file: rtl/uirq_regs_top.v
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "uirq_regs.vh"
// Notes on behaviour
// - Unit 0 transmit flag sets while its transmit buffer holds nothing.
// - Unit 0 receive flag sets when a full character reaches its buffer.
// - Unit 1 transmit flag sits at bit 5 of flag register 2, set on empty.
// - Unit 1 receive flag sits at bit 4 of flag register 2, set on receive.
// - Enable register 2 bit 5 gates the unit 1 transmit interrupt.
// - Enable register 2 bit 4 gates the unit 1 receive interrupt.
// - Reduced-pin variant keeps unit 0 enables at enable register 2 bits 1,0.
// - Unit 0 flags sit at flag 1 bits 7,6, or flag 2 bits 1,0 when reduced.
// - Other bit positions are free for other modules, held as plain bits.
// - A unit is in SPI mode only with sync mode 1 and two-wire mode 0.
// - Transmit request only when flag, enable and global enable are all set.
// - Transmit flag clears on service of its request or a buffer write.
// - Receive flag clears when software reads the receive buffer.
// - Reset or soft reset sets the transmit flag and clears both enables.
module uirq_regs_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [1:0] tx_empty,
    input wire [1:0] tx_load,
    input wire [1:0] tx_ack,
    input wire [1:0] rx_done,
    input wire [1:0] rx_read,
    output wire [1:0] tx_irq,
    output wire [1:0] rx_irq,
    output wire [1:0] spi_mode,
    output wire [1:0] soft_reset_bit,
    output wire irq
);
    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire acc;
    wire wr;
    wire rd;
    wire [6:0] hit;
    reg [7:0] ie1;
    reg [7:0] ie2;
    reg [7:0] free1;
    reg [7:0] free2;
    reg [7:0] ctrl;
    reg [3:0] evt;
    reg [3:0] evt_mask;
    wire [1:0] txf;
    wire [1:0] rxf;
    wire reduced;
    wire global_int_enable;
    wire [1:0] tx_en;
    wire [1:0] rx_en;
    wire [7:0] flag1_view;
    wire [7:0] flag2_view;
    wire [1:0] fwr;
    wire [1:0] fwr_tx;
    wire [1:0] fwr_rx;
    wire [3:0] evt_new;
    wire [7:0] next_ctrl;
    uirq_apb_slave u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .acc(acc),
        .wr(wr),
        .rd(rd),
        .hit(hit)
    );
    assign reduced = ctrl[`UIRQ_CTRL_REDUCED];
    assign global_int_enable = ctrl[`UIRQ_CTRL_GIE];
    // Soft reset clears the enables at the very edge that sets it, so no
    // interrupt leaks out in the cycle after the control write.
    assign next_ctrl = (wr && hit[4]) ? pwdata[7:0] : ctrl;
    assign soft_reset_bit = {ctrl[`UIRQ_CTRL_SRST1], ctrl[`UIRQ_CTRL_SRST0]};
    assign spi_mode[0] = ctrl[`UIRQ_CTRL_SYNC0]
        && !ctrl[`UIRQ_CTRL_TWO0];
    assign spi_mode[1] = ctrl[`UIRQ_CTRL_SYNC1]
        && !ctrl[`UIRQ_CTRL_TWO1];
    // ------------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------------
    // Unit 0 enable lives in register 1 or 2 by variant.
    assign tx_en[0] = reduced ? ie2[`UIRQ_TX0_R_BIT]
        : ie1[`UIRQ_TX0_BIT];
    assign rx_en[0] = reduced ? ie2[`UIRQ_RX0_R_BIT]
        : ie1[`UIRQ_RX0_BIT];
    assign tx_en[1] = ie2[`UIRQ_TX1_BIT];
    assign rx_en[1] = ie2[`UIRQ_RX1_BIT];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie1 <= `UIRQ_ZERO8;
            ie2 <= `UIRQ_ZERO8;
            free1 <= `UIRQ_ZERO8;
            free2 <= `UIRQ_ZERO8;
            ctrl <= `UIRQ_CTRL_RESET;
        end else begin
            if (wr && hit[0]) begin
                ie1 <= pwdata[7:0];
            end
            if (wr && hit[1]) begin
                ie2 <= pwdata[7:0];
            end
            if (wr && hit[2]) begin
                free1 <= pwdata[7:0];
            end
            if (wr && hit[3]) begin
                free2 <= pwdata[7:0];
            end
            if (wr && hit[4]) begin
                ctrl <= pwdata[7:0];
            end
            // Soft reset holds the unit's enables cleared.
            if (next_ctrl[`UIRQ_CTRL_SRST0]) begin
                if (next_ctrl[`UIRQ_CTRL_REDUCED]) begin
                    ie2[`UIRQ_TX0_R_BIT] <= 1'b0;
                    ie2[`UIRQ_RX0_R_BIT] <= 1'b0;
                end else begin
                    ie1[`UIRQ_TX0_BIT] <= 1'b0;
                    ie1[`UIRQ_RX0_BIT] <= 1'b0;
                end
            end
            if (next_ctrl[`UIRQ_CTRL_SRST1]) begin
                ie2[`UIRQ_TX1_BIT] <= 1'b0;
                ie2[`UIRQ_RX1_BIT] <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------------
    // Flags per unit
    // ------------------------------------------------------------------
    assign fwr[0] = wr && (reduced ? hit[3] : hit[2]);
    assign fwr_tx[0] = reduced ? pwdata[`UIRQ_TX0_R_BIT]
                               : pwdata[`UIRQ_TX0_BIT];
    assign fwr_rx[0] = reduced ? pwdata[`UIRQ_RX0_R_BIT]
                               : pwdata[`UIRQ_RX0_BIT];
    assign fwr[1] = wr && hit[3];
    assign fwr_tx[1] = pwdata[`UIRQ_TX1_BIT];
    assign fwr_rx[1] = pwdata[`UIRQ_RX1_BIT];
    genvar u;
    generate
        for (u = 0; u < 2; u = u + 1) begin : g_unit
            uirq_unit_flags u_flags (
                .pclk(pclk),
                .presetn(presetn),
                .soft_reset_bit(soft_reset_bit[u]),
                .tx_empty(tx_empty[u]),
                .tx_load(tx_load[u]),
                .tx_ack(tx_ack[u]),
                .rx_done(rx_done[u]),
                .rx_read(rx_read[u]),
                .wr_en(fwr[u]),
                .wr_tx(fwr_tx[u]),
                .wr_rx(fwr_rx[u]),
                .tx_empty_flag(txf[u]),
                .rx_full_flag(rxf[u])
            );
            assign tx_irq[u] = txf[u] && tx_en[u] && global_int_enable;
            assign rx_irq[u] = rxf[u] && rx_en[u] && global_int_enable;
        end
    endgenerate
    // Unit 0 flags appear only in the register of the selected variant.
    assign flag1_view = reduced ? free1
        : {txf[0], rxf[0], free1[5:0]};
    assign flag2_view = {free2[7:6], txf[1], rxf[1], free2[3:2],
        reduced ? {txf[0], rxf[0]} : free2[1:0]};
    // ------------------------------------------------------------------
    // Event status, cleared by read, and mask
    // ------------------------------------------------------------------
    assign evt_new = {rx_done[1], rx_done[0], tx_empty[1] & ~txf[1],
        tx_empty[0] & ~txf[0]};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt <= 4'h0;
            evt_mask <= 4'h0;
        end else begin
            // Only the bits captured for the reader are cleared, so an event
            // landing between setup and access is not lost. New events win.
            if (rd && hit[5]) begin
                evt <= (evt & ~prdata[3:0]) | evt_new;
            end else begin
                evt <= evt | evt_new;
            end
            if (wr && hit[6]) begin
                evt_mask <= pwdata[3:0];
            end
        end
    end
    assign irq = |(evt & evt_mask);
    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            // Captured in setup so data is stable during the access phase.
            case (paddr)
                `UIRQ_ADDR_IE1: prdata <= {24'h000000, ie1};
                `UIRQ_ADDR_IE2: prdata <= {24'h000000, ie2};
                `UIRQ_ADDR_SERIAL_IRQ_FLAG_1: prdata <= {24'h000000, flag1_view};
                `UIRQ_ADDR_SERIAL_IRQ_FLAG_2: prdata <= {24'h000000, flag2_view};
                `UIRQ_ADDR_CTRL: prdata <= {24'h000000, ctrl};
                `UIRQ_ADDR_EVT: prdata <= {28'h0000000, evt};
                `UIRQ_ADDR_EVT_MASK: prdata <= {28'h0000000, evt_mask};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // uirq_regs_top

// file: tb/uirq_regs_top_properties.sv
`timescale 1ns/1ps
// --------------------
// Port-level checks
// --------------------
module uirq_regs_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [1:0] tx_empty,
    input wire [1:0] tx_load,
    input wire [1:0] tx_ack,
    input wire [1:0] rx_done,
    input wire [1:0] rx_read,
    input wire [1:0] tx_irq,
    input wire [1:0] rx_irq,
    input wire [1:0] soft_reset_bit
);
    // A register write may move any flag or enable, so it excuses a change.
    wire wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_tx0_set;
        $rose(tx_irq[0]) && !$past(wr) |-> $past(tx_empty[0]);
    endproperty
    a_tx0_set: assert property (p_tx0_set) else $error("tx0 rise");
    property p_tx1_set;
        $rose(tx_irq[1]) && !$past(wr) |-> $past(tx_empty[1]);
    endproperty
    a_tx1_set: assert property (p_tx1_set) else $error("tx1 rise");
    property p_rx0_set;
        $rose(rx_irq[0]) && !$past(wr) |-> $past(rx_done[0]);
    endproperty
    a_rx0_set: assert property (p_rx0_set) else $error("rx0 rise");
    property p_rx1_set;
        $rose(rx_irq[1]) && !$past(wr) |-> $past(rx_done[1]);
    endproperty
    a_rx1_set: assert property (p_rx1_set) else $error("rx1 rise");
    property p_tx_ack;
        tx_ack[0] && !tx_empty[0] |=> !tx_irq[0];
    endproperty
    a_tx_ack: assert property (p_tx_ack) else $error("ack kept");
    property p_tx_hold;
        tx_irq[1] && !tx_ack[1] && !tx_load[1] && !wr |=> tx_irq[1];
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx1 lost");
    property p_rx_read;
        rx_read[0] && !rx_done[0] |=> !rx_irq[0];
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("read kept");
    property p_srst;
        !(|(soft_reset_bit & (tx_irq | rx_irq)));
    endproperty
    a_srst: assert property (p_srst) else $error("irq in reset");
endmodule // uirq_regs_checker

bind uirq_regs_top uirq_regs_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .tx_empty(tx_empty), .tx_load(tx_load),
    .tx_ack(tx_ack), .rx_done(rx_done), .rx_read(rx_read),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .soft_reset_bit(soft_reset_bit)
);

// file: tb/uirq_regs_top_tb.sv
`timescale 1ns/1ps
module uirq_regs_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] tx_empty, tx_load, tx_ack, rx_done, rx_read;
    logic [1:0] tx_irq, rx_irq, spi_mode, soft_reset_bit;
    int miscompares, checked, k;

    uirq_regs_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_empty(tx_empty),
        .tx_load(tx_load), .tx_ack(tx_ack), .rx_done(rx_done),
        .rx_read(rx_read), .tx_irq(tx_irq), .rx_irq(rx_irq),
        .spi_mode(spi_mode), .soft_reset_bit(soft_reset_bit), .irq(irq)
    );

    // --------------------
    // Bus and event tasks
    // --------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
        @(negedge pclk);
    endtask

    task rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(q, e);
    endtask

    // Fields: empty, load, ack, done, read; two bits each, unit 1 high.
    task ev(input logic [9:0] v);
        @(posedge pclk);
        {tx_empty, tx_load, tx_ack, rx_done, rx_read} <= v;
        @(posedge pclk);
        {tx_empty, tx_load, tx_ack, rx_done, rx_read} <= 10'h0;
        @(negedge pclk);
    endtask

    task final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        final_report;
    end

    // --------------------
    // Scenarios
    // --------------------
    initial begin
        {presetn, psel, penable, pwrite, err} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        {tx_empty, tx_load, tx_ack, rx_done, rx_read} = 10'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        rc(12'h000, 32'h0);
        rc(12'h004, 32'h0);
        rc(12'h008, 32'h80);
        rc(12'h00c, 32'h20);
        chk(soft_reset_bit, 2'h3);
        wr(12'h010, 32'h01);
        wr(12'h000, 32'hc0);
        wr(12'h004, 32'h30);
        chk(tx_irq, 2'h3);
        ev(10'h010);
        chk(tx_irq, 2'h2);
        rc(12'h008, 32'h0);
        ev(10'h080);
        chk(tx_irq, 2'h0);
        ev(10'h200);
        chk(tx_irq, 2'h2);
        ev(10'h00c);
        chk(rx_irq, 2'h3);
        rc(12'h008, 32'h40);
        rc(12'h00c, 32'h30);
        chk(irq, 1'h0);
        wr(12'h018, 32'h0f);
        chk(irq, 1'h1);
        rc(12'h014, 32'h0e);
        @(negedge pclk);
        chk(irq, 1'h0);
        ev(10'h003);
        chk(rx_irq, 2'h0);
        rc(12'h008, 32'h0);
        wr(12'h004, 32'h10);
        chk(tx_irq, 2'h0);
        ev(10'h008);
        chk(rx_irq, 2'h2);
        wr(12'h004, 32'h20);
        chk(rx_irq, 2'h0);
        wr(12'h010, 32'h00);
        chk(tx_irq, 2'h0);
        wr(12'h000, 32'h0);
        wr(12'h010, 32'h81);
        wr(12'h004, 32'h22);
        ev(10'h100);
        chk(tx_irq, 2'h3);
        rc(12'h00c, 32'h32);
        for (k = 0; k < 4; k++) begin
            wr(12'h010, {25'h0, k[1], k[0], k[1], k[0], 3'h0});
            chk(spi_mode, (k == 1) ? 2'h3 : 2'h0);
        end
        wr(12'h000, 32'hc0);
        wr(12'h004, 32'h30);
        wr(12'h010, 32'h07);
        chk({tx_irq, rx_irq}, 32'h0);
        rc(12'h000, 32'h0);
        rc(12'h004, 32'h0);
        rc(12'h008, 32'h80);
        apb(1'h0, 12'h01c, 32'h0);
        chk(err, 1'h1);
        chk(q, 32'h0);
        final_report;
    end
endmodule // uirq_regs_top_tb
